// file: rtl/pwm_clk_map.svh
`ifndef PWM_CLK_MAP_SVH
`define PWM_CLK_MAP_SVH
`define SWF_OSC_MSB       6
`define SWF_OSC_LSB       4
`define SWF_DIV_MSB       2
`define SWF_DIV_LSB       0
`define SYNC_EXT_EN       0
`define SYNC_MASTER       1
`define SYNC_SLAVE        2
`define SYNC_AUTO_BACK    3
`define OSC_BASE_KHZ      16'hBB80
`define OSC_STEP_KHZ      16'h0C80
`define MIN_OSC_PER_DIV   16'h12C0
`define MAX_FREQ_KHZ      16'h05DC
`define PERIOD_UNIT       8'h10
`define DIV_INVALID       3'h0
`define PCT_FULL          16'h0064
`define CLK_PERIOD_NS     25
`define MIN_ON_NS         40
`define MIN_ON_CYC        ((`MIN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAXD_D1           7'h4E
`define MAXD_D2           7'h56
`define MAXD_D3           7'h54
`define MAXD_D4           7'h59
`define MAXD_D5           7'h58
`define MAXD_D6           7'h58
`define MAXD_D7           7'h56
`endif

// file: rtl/pwm_clk_pkg.sv
package pwm_clk_pkg;
	typedef enum logic [1:0] {st_load, st_int, st_measure, st_ext} clk_state_t;
endpackage : pwm_clk_pkg

// file: rtl/pwm_channel.sv
`timescale 1ns/1ps
`include "pwm_clk_map.svh"
module pwm_channel (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic       wrap,
	input  wire logic [7:0] cnt,
	input  wire logic [7:0] period,
	input  wire logic [6:0] duty_cmd,
	input  wire logic [6:0] duty_limit,
	output logic            pwm_hi,
	output logic            clamped
);
	logic [6:0]  eff;
	logic [15:0] prod;
	logic [7:0]  on_calc;
	logic [7:0]  on_reg;

	always_comb begin
		eff = (duty_cmd > duty_limit) ? duty_limit : duty_cmd;
		prod = {8'h00, period} * {9'h000, eff};
		on_calc = 8'(prod / `PCT_FULL);
		if (eff != 7'h00 && on_calc < 8'(`MIN_ON_CYC)) begin
			on_calc = 8'(`MIN_ON_CYC);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			on_reg <= 8'h00;
			clamped <= 1'b0;
		end else if (wrap) begin
			on_reg <= on_calc;
			clamped <= duty_cmd > duty_limit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwm_hi <= 1'b0;
		end else begin
			pwm_hi <= run && (cnt < on_reg);
		end
	end

	a_min_on_time: assert property (@(posedge clk) disable iff (!nrst)
		$rose(pwm_hi) |-> pwm_hi ##1 pwm_hi)
		else $error("pulse shorter than minimum on time");
	a_duty_clamp: assert property (@(posedge clk) disable iff (!nrst)
		wrap |=> ({8'h00, on_reg} * `PCT_FULL
			<= {8'h00, $past(period)} * {9'h000, $past(duty_limit)})
			|| on_reg == 8'(`MIN_ON_CYC))
		else $error("on time exceeds duty limit");
endmodule : pwm_channel

// file: rtl/pwm_clock_select_sync.sv
`timescale 1ns/1ps
`include "pwm_clk_map.svh"
// Behaviour
// - the switching frequency is the oscillator rate over the divider, 1.5MHz fastest, 300KHz slowest.
// - divider code 000 and any setting below 300KHz are rejected and produce no pulses.
// - the maximum duty cycle follows the divider code, 78/86/84/89/88/88/86 percent for 001..111.
// - every high-side pulse lasts at least the 40ns minimum on time.
// - each channel pulse is clamped at its programmed duty limit, unless the 40ns minimum on time is longer.
// - the sync mode setting selects external clock use and master or slave pairing.
// - after power-up the device always runs on its internal clock first.
// - the main clock moves to the external source only when its measured rate is inside the window.
// - without a valid external clock the device stays on the internal clock and ignores the input.
// - with automatic switch-back on, a failed external clock returns the main clock to internal.
// - a master drives clock and sync outputs only after its configuration has loaded.
// - a slave loads configuration on the internal clock, then adopts the master clock.
// - bits 6..4 pick the oscillator from 48MHz down to 25.6MHz and bits 2..0 the divider.
module pwm_clock_select_sync #(
	parameter int NUM_CH        = 3,
	parameter int EXT_NOM_CYC   = 8,
	parameter int MEAS_EDGES    = 16,
	parameter int FAIL_GAP      = 32,
	parameter int CLK_OUT_HALF  = 4
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic [7:0]            switching_frequency_select,
	input  wire logic [3:0]            sync_mode_config,
	input  wire logic [6:0]            freq_window_pct,
	input  wire logic                  cfg_loaded,
	input  wire logic                  ext_clk_in,
	input  wire logic [NUM_CH*7-1:0]   duty_cmd,
	input  wire logic [NUM_CH*7-1:0]   channel_duty_limit,
	output logic      [NUM_CH-1:0]     pwm_hi,
	output logic      [NUM_CH-1:0]     duty_clamped,
	output logic      [15:0]           pwm_freq_khz,
	output logic      [6:0]            max_duty_pct,
	output logic                       freq_cfg_valid,
	output logic                       on_external,
	output logic                       clk_out,
	output logic                       clk_out_oe,
	output logic                       sync_out,
	output logic                       sync_out_oe
);
	pwm_clk_pkg::clk_state_t state_reg;
	pwm_clk_pkg::clk_state_t state_next;
	logic [2:0]  osc_code;
	logic [2:0]  div_code;
	logic [15:0] osc_khz;
	logic [15:0] div_plus;
	logic        cfg_ok;
	logic        ext_en;
	logic        is_master;
	logic        is_slave;
	logic        auto_back;
	logic        ext_s1_reg;
	logic        ext_s2_reg;
	logic        ext_s3_reg;
	logic        ext_rise;
	logic [7:0]  gap_reg;
	logic        ext_dead;
	logic [4:0]  edge_cnt_reg;
	logic [11:0] meas_cnt_reg;
	logic [11:0] nom_total;
	logic [11:0] diff;
	logic        meas_done;
	logic        meas_pass;
	logic        use_ext_reg;
	logic        tick;
	logic        wrap;
	logic        run;
	logic [7:0]  cnt_reg;
	logic [7:0]  period_reg;
	logic [7:0]  half_cnt_reg;
	logic        master_on;

	always_comb begin
		osc_code = switching_frequency_select[`SWF_OSC_MSB:`SWF_OSC_LSB];
		div_code = switching_frequency_select[`SWF_DIV_MSB:`SWF_DIV_LSB];
		osc_khz = 16'(`OSC_BASE_KHZ - `OSC_STEP_KHZ * {13'h0000, osc_code});
		div_plus = {13'h0000, div_code} + 16'h0001;
		cfg_ok = div_code != `DIV_INVALID
			&& osc_khz >= 16'(`MIN_OSC_PER_DIV * div_plus);
		ext_en = sync_mode_config[`SYNC_EXT_EN];
		is_master = sync_mode_config[`SYNC_MASTER];
		is_slave = sync_mode_config[`SYNC_SLAVE];
		auto_back = sync_mode_config[`SYNC_AUTO_BACK];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwm_freq_khz <= 16'h0000;
			freq_cfg_valid <= 1'b0;
			max_duty_pct <= 7'h00;
		end else begin
			freq_cfg_valid <= cfg_ok;
			pwm_freq_khz <= cfg_ok ? 16'(osc_khz / 16'(`PERIOD_UNIT * div_plus)) : 16'h0000;
			case (div_code)
				3'h1: max_duty_pct <= `MAXD_D1;
				3'h2: max_duty_pct <= `MAXD_D2;
				3'h3: max_duty_pct <= `MAXD_D3;
				3'h4: max_duty_pct <= `MAXD_D4;
				3'h5: max_duty_pct <= `MAXD_D5;
				3'h6: max_duty_pct <= `MAXD_D6;
				3'h7: max_duty_pct <= `MAXD_D7;
				default: max_duty_pct <= 7'h00;
			endcase
		end
	end

	// external clock pin synchroniser and edge finder
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_clk_in;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end
	assign ext_rise = ext_s2_reg && !ext_s3_reg;
	assign ext_dead = gap_reg >= 8'(FAIL_GAP);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_reg <= 8'h00;
		end else if (ext_rise) begin
			gap_reg <= 8'h00;
		end else if (!ext_dead) begin
			gap_reg <= gap_reg + 8'h01;
		end
	end

	// frequency detector: clk cycles across MEAS_EDGES external periods
	always_comb begin
		nom_total = 12'(EXT_NOM_CYC * MEAS_EDGES);
		diff = (meas_cnt_reg > nom_total) ? meas_cnt_reg - nom_total : nom_total - meas_cnt_reg;
		meas_done = state_reg == pwm_clk_pkg::st_measure && ext_rise
			&& edge_cnt_reg == 5'(MEAS_EDGES);
		meas_pass = {8'h00, diff} * 20'h00064 <= {8'h00, nom_total} * {13'h0000, freq_window_pct};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			edge_cnt_reg <= 5'h00;
			meas_cnt_reg <= 12'h000;
		end else if (state_reg != pwm_clk_pkg::st_measure) begin
			edge_cnt_reg <= 5'h00;
			meas_cnt_reg <= 12'h000;
		end else begin
			if (ext_rise) begin
				edge_cnt_reg <= edge_cnt_reg + 5'h01;
			end
			if (edge_cnt_reg != 5'h00 && meas_cnt_reg != 12'hFFF) begin
				meas_cnt_reg <= meas_cnt_reg + 12'h001;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pwm_clk_pkg::st_load: begin
				if (cfg_loaded) begin
					state_next = (ext_en || is_slave) ? pwm_clk_pkg::st_measure
						: pwm_clk_pkg::st_int;
				end
			end
			pwm_clk_pkg::st_measure: begin
				if (ext_dead) begin
					state_next = pwm_clk_pkg::st_int;
				end else if (meas_done) begin
					state_next = meas_pass ? pwm_clk_pkg::st_ext : pwm_clk_pkg::st_int;
				end
			end
			pwm_clk_pkg::st_ext: begin
				if (ext_dead && auto_back) begin
					state_next = pwm_clk_pkg::st_int;
				end
			end
			default: state_next = state_reg;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= pwm_clk_pkg::st_load;
		end else begin
			state_reg <= state_next;
		end
	end

	// source change only at a period wrap, or while the external clock is stalled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			use_ext_reg <= 1'b0;
		end else if (state_reg == pwm_clk_pkg::st_ext && wrap) begin
			use_ext_reg <= 1'b1;
		end else if (state_reg != pwm_clk_pkg::st_ext && (wrap || ext_dead)) begin
			use_ext_reg <= 1'b0;
		end
	end
	assign on_external = use_ext_reg;

	always_comb begin
		run = state_reg != pwm_clk_pkg::st_load && freq_cfg_valid;
		tick = use_ext_reg ? ext_rise : 1'b1;
		wrap = run && tick && cnt_reg == period_reg - 8'h01;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 8'h00;
			period_reg <= `PERIOD_UNIT;
		end else if (!run || wrap) begin
			cnt_reg <= 8'h00;
			period_reg <= 8'(`PERIOD_UNIT * ({5'h00, div_code} + 8'h01));
		end else if (tick) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			pwm_channel u_ch (
				.clk        (clk),
				.nrst       (nrst),
				.run        (run),
				.wrap       (wrap),
				.cnt        (cnt_reg),
				.period     (period_reg),
				.duty_cmd   (duty_cmd[ch*7 +: 7]),
				.duty_limit (channel_duty_limit[ch*7 +: 7]),
				.pwm_hi     (pwm_hi[ch]),
				.clamped    (duty_clamped[ch])
			);
		end
	endgenerate

	// master clock and sync outputs
	assign master_on = is_master && state_reg != pwm_clk_pkg::st_load;
	assign clk_out_oe = master_on;
	assign sync_out_oe = master_on;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clk_out <= 1'b0;
			half_cnt_reg <= 8'h00;
			sync_out <= 1'b0;
		end else begin
			sync_out <= master_on && wrap;
			if (!master_on) begin
				clk_out <= 1'b0;
				half_cnt_reg <= 8'h00;
			end else if (tick) begin
				if (half_cnt_reg == 8'(CLK_OUT_HALF - 1)) begin
					half_cnt_reg <= 8'h00;
					clk_out <= !clk_out;
				end else begin
					half_cnt_reg <= half_cnt_reg + 8'h01;
				end
			end
		end
	end

	a_start_internal: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == pwm_clk_pkg::st_load |-> !use_ext_reg)
		else $error("external clock in use before load finished");
	a_ext_needs_pass: assert property (@(posedge clk) disable iff (!nrst)
		$rose(use_ext_reg) |-> $past(state_reg == pwm_clk_pkg::st_ext))
		else $error("switched to external without a passing measurement");
	a_switch_at_wrap: assert property (@(posedge clk) disable iff (!nrst)
		$changed(use_ext_reg) |-> $past(wrap) || $past(ext_dead))
		else $error("source changed mid period");
	a_stay_internal: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == pwm_clk_pkg::st_int && !use_ext_reg) |=> !use_ext_reg)
		else $error("internal mode picked up external clock");
	a_switch_back: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == pwm_clk_pkg::st_ext && ext_dead && auto_back)
			|=> state_reg == pwm_clk_pkg::st_int ##[0:130] !use_ext_reg)
		else $error("no switch back after clock failure");
	a_master_gate: assert property (@(posedge clk) disable iff (!nrst)
		(clk_out || sync_out || clk_out_oe) |-> $past(state_reg != pwm_clk_pkg::st_load)
			|| state_reg != pwm_clk_pkg::st_load)
		else $error("master outputs before configuration loaded");
	a_sync_on_wrap: assert property (@(posedge clk) disable iff (!nrst)
		$rose(sync_out) |-> $past(wrap) ##1 !sync_out)
		else $error("sync pulse not tied to period start");
	a_div_reject: assert property (@(posedge clk) disable iff (!nrst)
		div_code == `DIV_INVALID |=> !freq_cfg_valid && pwm_freq_khz == 16'h0000)
		else $error("invalid divider accepted");
	a_freq_bound: assert property (@(posedge clk) disable iff (!nrst)
		freq_cfg_valid |-> pwm_freq_khz <= `MAX_FREQ_KHZ)
		else $error("switching frequency above maximum");
	a_pwm_off_load: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == pwm_clk_pkg::st_load |=> pwm_hi == '0)
		else $error("pulses while configuration loading");
endmodule : pwm_clock_select_sync

// file: bench/ext_clk_source.sv
`timescale 1ns/1ps
module ext_clk_source (
	input  wire logic       run,
	input  wire logic [7:0] half_ns,
	output logic            ext_clk
);
	initial begin
		ext_clk = 1'b0;
		#3;
	end
	// a stopped source holds its line low, as a failed clock would
	always begin
		if (run) begin
			#(half_ns) ext_clk = ~ext_clk;
		end else begin
			#1 ext_clk = 1'b0;
		end
	end
endmodule : ext_clk_source

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        nrst;
	logic [7:0]  sw_sel;
	logic [3:0]  mode;
	logic        loaded;
	logic        run_ext;
	logic [7:0]  half_ns;
	logic [6:0]  win;
	logic        ext_clk;
	logic [20:0] cmd;
	logic [20:0] lim;
	logic [2:0]  pwm_hi;
	logic [2:0]  clamped;
	logic [15:0] freq;
	logic [6:0]  maxd;
	logic        valid;
	logic        on_ext;
	logic        clk_out;
	logic        clk_oe;
	logic        sync_out;
	logic        sync_oe;
	logic [31:0] seed;
	logic [31:0] r;
	int          bad_count;
	int          samples_checked;
	int          n;
	int          t;
	int          s;
	logic        seen;
	logic        last;
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		sw_sel = 8'h01;
		mode = 4'h0;
		loaded = 1'b0;
		run_ext = 1'b0;
		half_ns = 8'h64;
		cmd = 21'h0;
		lim = 21'h0;
		win = 7'h0A;
		seed = 32'h56D6;
		bad_count = 0;
		samples_checked = 0;
	end
	always #12.5 clk = ~clk;
	ext_clk_source partner_u (.run(run_ext), .half_ns(half_ns), .ext_clk(ext_clk));
	pwm_clock_select_sync dut_u (
		.clk(clk), .nrst(nrst), .switching_frequency_select(sw_sel),
		.sync_mode_config(mode), .freq_window_pct(win), .cfg_loaded(loaded),
		.ext_clk_in(ext_clk), .duty_cmd(cmd), .channel_duty_limit(lim),
		.pwm_hi(pwm_hi), .duty_clamped(clamped), .pwm_freq_khz(freq),
		.max_duty_pct(maxd), .freq_cfg_valid(valid), .on_external(on_ext),
		.clk_out(clk_out), .clk_out_oe(clk_oe), .sync_out(sync_out),
		.sync_out_oe(sync_oe));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] exp_freq(input logic [2:0] o, input logic [2:0] d);
		int osc;
		osc = 48000 - 3200 * o;
		if (d == 3'h0 || osc < 4800 * (d + 1)) begin
			return 16'h0000;
		end
		return 16'(osc / (16 * (d + 1)));
	endfunction : exp_freq
	function automatic logic [15:0] exp_maxd(input logic [2:0] d);
		case (d)
			3'h1: return 16'h004E;
			3'h2: return 16'h0056;
			3'h3: return 16'h0054;
			3'h4: return 16'h0059;
			3'h5, 3'h6: return 16'h0058;
			3'h7: return 16'h0056;
			default: return 16'h0000;
		endcase
	endfunction : exp_maxd
	function automatic int exp_on(input int c, input int l);
		int e;
		e = (c < l) ? c : l;
		if (e == 0) begin
			return 0;
		end
		return (32 * e / 100 < 2) ? 2 : 32 * e / 100;
	endfunction : exp_on
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic do_reset(input logic [3:0] m);
		@(negedge clk);
		nrst = 1'b0;
		loaded = 1'b0;
		run_ext = 1'b0;
		mode = m;
		win = 7'h0A;
		sw_sel = 8'h01;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
	endtask : do_reset
	task automatic wait_ext(input logic v, input int bound);
		t = 0;
		while (on_ext !== v && t < bound) begin
			@(negedge clk);
			t++;
		end
		if (on_ext !== v) begin
			check("on_external wait", {15'h0, v}, {15'h0, on_ext});
			give_verdict();
		end
	endtask : wait_ext
	task automatic measure_on(output int w);
		w = 0;
		t = 0;
		while (pwm_hi[0] !== 1'b0 && t < 100) begin @(negedge clk); t++; end
		while (pwm_hi[0] !== 1'b1 && t < 100) begin @(negedge clk); t++; end
		while (pwm_hi[0] === 1'b1 && w < 100) begin @(negedge clk); w++; end
	endtask : measure_on
	initial begin
		do_reset(4'h0);
		loaded = 1'b1;
		for (int i = 0; i < 72; i++) begin
			r = rnd();
			sw_sel = (i < 64) ? {1'b0, 3'(i >> 3), 1'b0, 3'(i)} : r[7:0];
			repeat (2) @(negedge clk);
			check("freq", exp_freq(sw_sel[6:4], sw_sel[2:0]), freq);
			check("valid", 16'(exp_freq(sw_sel[6:4], sw_sel[2:0]) != 0), 16'(valid));
			check("max duty", exp_maxd(sw_sel[2:0]), 16'(maxd));
		end
		sw_sel = 8'h01;
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			n = (i == 0) ? 1 : (i == 1) ? 0 : r[15:0] % 100;
			s = (i == 2) ? 40 : 50 + r[23:16] % 45;
			cmd = {3{7'(n)}};
			lim = {3{7'(s)}};
			repeat (70) @(negedge clk);
			check("clamped", 16'({3{n > s}}), 16'(clamped));
			measure_on(t);
			check("on ticks", 16'(exp_on(n, s)), 16'(t));
			check("channel match", 16'({3{pwm_hi[0]}}), 16'(pwm_hi));
		end
		for (int k = 0; k < 3; k++) begin
			do_reset(k == 0 ? 4'h9 : k == 1 ? 4'h4 : 4'h1);
			half_ns = (k == 2) ? 8'h96 : 8'h64;
			win = (k == 2) ? 7'h3C : 7'h0A;
			run_ext = 1'b1;
			loaded = 1'b1;
			repeat (2) @(negedge clk);
			check("start internal", 16'h0, 16'(on_ext));
			wait_ext(1'b1, 600);
			check("on external", 16'h1, 16'(on_ext));
		end
		do_reset(4'h9);
		half_ns = 8'h64;
		run_ext = 1'b1;
		loaded = 1'b1;
		wait_ext(1'b1, 600);
		run_ext = 1'b0;
		wait_ext(1'b0, 100);
		check("switch back", 16'h0, 16'(on_ext));
		do_reset(4'h1);
		half_ns = 8'h96;
		run_ext = 1'b1;
		loaded = 1'b1;
		seen = 1'b0;
		repeat (600) begin
			@(negedge clk);
			seen |= (on_ext === 1'b1);
		end
		check("out of window", 16'h0, 16'(seen));
		do_reset(4'h2);
		repeat (8) @(negedge clk);
		check("oe before load", 16'h0, {14'h0, clk_oe, sync_oe});
		loaded = 1'b1;
		repeat (40) @(negedge clk);
		check("oe after load", 16'h3, {14'h0, clk_oe, sync_oe});
		n = 0;
		s = 0;
		last = clk_out;
		repeat (64) begin
			@(negedge clk);
			n += (clk_out !== last);
			s += (sync_out === 1'b1);
			last = clk_out;
		end
		check("clk_out toggles", 16'h0010, 16'(n));
		check("sync pulses", 16'h0002, 16'(s));
		give_verdict();
	end
endmodule : tb_top
